// ---- hw/csw_detector.v ----
// cyclic sense wake detector with apb registers
//
// Design decisions made here: the register offsets and register access over APB.
`default_nettype none
module csw_detector (
    input  wire        CORE_CLK,
    input  wire        RESET_N,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        SENSED_WAKE_INPUT,
    input  wire        GPIO_WAKE_INPUT,
    output reg         HIGH_SIDE_DRIVER,
    output reg         INTERRUPT_OUT_LOW,
    output reg         MAIN_SUPPLY_RAIL,
    output reg         RESET_OUT_LOW
);
`include "csw_regs.vh"
    localparam [15:0] FILT_CYC = `CSW_FILT_CYC; // 16us in clocks
    localparam [4:0] ST_IDLE = 5'h01; // timer stopped
    localparam [4:0] ST_ON   = 5'h02; // driver on, sensing
    localparam [4:0] ST_FILT = 5'h04; // filter after on-time
    localparam [4:0] ST_OFF  = 5'h08; // rest of period
    reg  [3:0]  period_sel;   // period code
    reg  [2:0]  on_sel;       // on-time code
    reg  [2:0]  gpio_cfg;     // gpio function code
    reg         wake_input_enable;  // static/cyclic wake source
    reg         gpio_wake_en;       // gpio as static wake
    reg         wake_input_event_flag;
    reg         wake_level_bit;
    reg         gpio_event_flag;
    reg         spi_fail;     // configuration fault
    reg  [1:0]  mode;         // device mode
    reg  [4:0]  state;
    reg  [23:0] tcnt;         // 0.1ms ticks in period
    reg  [15:0] fcnt;         // filter clocks
    reg         ref_level;    // previous cycle sample
    reg         ref_valid;    // reference learnt
    reg         filt_ok;      // level stable in filter
    reg         samp;         // level at on-time end
    reg         st_prev;      // static sense previous
    reg         gp_prev;
    reg  [7:0]  rst_cnt;      // restart hold
    wire        tick;
    reg  [23:0] per_ticks;
    reg  [23:0] on_ticks;
    wire        on_valid = (on_sel != `CSW_ON_OFFL) && (on_sel != `CSW_ON_OFFH1)
                           && (on_sel != `CSW_ON_OFFH2);
    wire        cyc_cfg = gpio_cfg == `CSW_GPIO_HSCS;
    wire        wr = PSEL && PENABLE && PWRITE;
    wire        acc = PSEL && PENABLE;
    wire        wr_timer = wr && (PADDR == `CSW_A_TIMER);
    wire        wr_mode = wr && (PADDR == `CSW_A_MODE);
    reg         cyc_wake;     // wake from cyclic sense
    reg         stat_upd;     // sample updates status
    reg         static_wake;
    reg         next_valid;
    reg         sleep_req;    // sleep write in normal/stop
    reg         no_source;    // no usable wake source
    reg         enter_rst;    // restart entered this edge

    csw_tick u_tick (
        .clk     (CORE_CLK),
        .reset_n (RESET_N),
        .clr     (wr_timer),
        .tick    (tick)
    );

    // period decode in 0.1ms ticks
    always @* begin
        case (period_sel)
            4'h0: per_ticks = 24'd100;
            4'h1: per_ticks = 24'd200;
            4'h2: per_ticks = 24'd500;
            4'h3: per_ticks = 24'd1000;
            4'h4: per_ticks = 24'd2000;
            4'h5: per_ticks = 24'd5000;
            4'h6: per_ticks = 24'd10000;
            4'h7: per_ticks = 24'd20000;
            4'h8: per_ticks = 24'd50000;
            4'h9: per_ticks = 24'd100000;
            4'ha: per_ticks = 24'd200000;
            4'hb: per_ticks = 24'd500000;
            4'hc: per_ticks = 24'd1000000;
            4'hd: per_ticks = 24'd2000000;
            4'he: per_ticks = 24'd5000000;
            default: per_ticks = 24'd10000000;
        endcase
        case (on_sel)
            3'h1: on_ticks = 24'd1;
            3'h2: on_ticks = 24'd3;
            3'h3: on_ticks = 24'd10;
            3'h4: on_ticks = 24'd100;
            3'h5: on_ticks = 24'd200;
            default: on_ticks = 24'd0;
        endcase
    end

    // cyclic wake decision at filter end, static wake every cycle
    always @* begin
        next_valid  = ref_valid;
        cyc_wake    = 1'b0;
        stat_upd    = 1'b0;
        if (state == ST_FILT && fcnt == FILT_CYC && cyc_cfg && wake_input_enable) begin
            next_valid = 1'b1;
            stat_upd = (mode != `CSW_MD_STOP) || (on_sel == `CSW_ON_SHORT);
            cyc_wake = ref_valid && filt_ok && (samp != ref_level);
        end
        static_wake = (!cyc_cfg && wake_input_enable && SENSED_WAKE_INPUT != st_prev)
                      || (gpio_wake_en && GPIO_WAKE_INPUT != gp_prev);
        // restart entry, shared so the driver drops with the reset output
        sleep_req = wr_mode && (PWDATA[1:0] == `CSW_MD_SLEEP)
                    && (mode == `CSW_MD_NORMAL || mode == `CSW_MD_STOP);
        no_source = !gpio_wake_en && !(wake_input_enable && (!cyc_cfg || on_valid));
        enter_rst = (sleep_req && (wake_input_event_flag || gpio_event_flag || no_source))
                    || (mode == `CSW_MD_SLEEP && (cyc_wake || static_wake));
    end

    // timer sequencer and sampling
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state     <= ST_IDLE;
            tcnt      <= 24'h000000;
            fcnt      <= 16'h0000;
            ref_level <= 1'b0;
            ref_valid <= 1'b0;
            filt_ok   <= 1'b0;
            samp      <= 1'b0;
            HIGH_SIDE_DRIVER <= 1'b0;
        end else if (mode == `CSW_MD_RESTART || enter_rst) begin
            state     <= ST_IDLE;
            tcnt      <= 24'h000000;
            ref_valid <= 1'b0;
            HIGH_SIDE_DRIVER <= 1'b0;
        end else if (wr_timer) begin
            // fresh start on each on-time write; relearn reference
            state     <= on_valid_w(PWDATA[6:4]) ? ST_ON : ST_IDLE;
            tcnt      <= 24'h000000;
            ref_valid <= 1'b0;
            HIGH_SIDE_DRIVER <= on_valid_w(PWDATA[6:4]) && (gpio_cfg == `CSW_GPIO_HSCS);
        end else begin
            ref_valid <= next_valid;
            if (tick && state != ST_IDLE) begin
                tcnt <= (tcnt + 24'h000001 >= per_ticks) ? 24'h000000 : tcnt + 24'h000001;
            end
            case (state)
                ST_IDLE: begin
                    HIGH_SIDE_DRIVER <= 1'b0;
                end
                ST_ON: begin
                    HIGH_SIDE_DRIVER <= cyc_cfg;
                    if (tick && tcnt + 24'h000001 >= on_ticks) begin
                        state   <= ST_FILT;
                        fcnt    <= 16'h0000;
                        samp    <= SENSED_WAKE_INPUT;
                        filt_ok <= 1'b1;
                    end
                end
                ST_FILT: begin
                    HIGH_SIDE_DRIVER <= cyc_cfg;
                    if (SENSED_WAKE_INPUT != samp) begin
                        filt_ok <= 1'b0;
                    end
                    if (fcnt == FILT_CYC) begin
                        state <= ST_OFF;
                        HIGH_SIDE_DRIVER <= 1'b0;
                        if (next_valid) begin
                            ref_level <= samp;
                        end
                    end else begin
                        fcnt <= fcnt + 16'h0001;
                    end
                end
                ST_OFF: begin
                    HIGH_SIDE_DRIVER <= 1'b0;
                    if (tick && tcnt + 24'h000001 >= per_ticks) begin
                        state <= ST_ON;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // on-time code validity
    function on_valid_w;
        input [2:0] c;
        begin
            on_valid_w = (c != `CSW_ON_OFFL) && (c != `CSW_ON_OFFH1) && (c != `CSW_ON_OFFH2);
        end
    endfunction

    // registers, status, mode control
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            period_sel <= 4'h0;
            on_sel     <= 3'h0;
            gpio_cfg   <= 3'h0;
            wake_input_enable <= 1'b0;
            gpio_wake_en <= 1'b0;
            wake_input_event_flag <= 1'b0;
            wake_level_bit <= 1'b0;
            gpio_event_flag <= 1'b0;
            spi_fail   <= 1'b0;
            mode       <= `CSW_MD_NORMAL;
            rst_cnt    <= 8'h00;
            st_prev    <= 1'b0;
            gp_prev    <= 1'b0;
            PRDATA     <= 32'h00000000;
            PREADY     <= 1'b0;
            PSLVERR    <= 1'b0;
            INTERRUPT_OUT_LOW <= 1'b1;
            MAIN_SUPPLY_RAIL  <= 1'b1;
            RESET_OUT_LOW     <= 1'b0;
        end else begin
            st_prev <= SENSED_WAKE_INPUT;
            gp_prev <= GPIO_WAKE_INPUT;
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            INTERRUPT_OUT_LOW <= 1'b1;
            if (PSEL && !PENABLE) begin
                PSLVERR <= PADDR > `CSW_A_STATE || PADDR[1:0] != 2'h0;
                case (PADDR)
                    `CSW_A_TIMER: PRDATA <= {25'h0, on_sel, period_sel};
                    `CSW_A_GPIO:  PRDATA <= {29'h0, gpio_cfg};
                    `CSW_A_WKCTL: PRDATA <= {30'h0, gpio_wake_en, wake_input_enable};
                    `CSW_A_STAT0: PRDATA <= {30'h0, gpio_event_flag, wake_input_event_flag};
                    `CSW_A_STAT1: PRDATA <= {31'h0, wake_level_bit};
                    `CSW_A_MODE:  PRDATA <= {30'h0, mode};
                    `CSW_A_STATE: PRDATA <= {26'h0, spi_fail, state};
                    default:      PRDATA <= 32'h00000000;
                endcase
            end
            if (wr && mode != `CSW_MD_RESTART) begin
                case (PADDR)
                    `CSW_A_TIMER: begin
                        period_sel <= PWDATA[3:0];
                        on_sel     <= PWDATA[6:4];
                    end
                    `CSW_A_GPIO:  gpio_cfg <= PWDATA[2:0];
                    `CSW_A_WKCTL: begin
                        wake_input_enable <= PWDATA[0];
                        gpio_wake_en      <= PWDATA[1];
                    end
                    `CSW_A_STAT1: spi_fail <= spi_fail & ~PWDATA[5];
                    default: ;
                endcase
            end
            // on-time above period flags a fault
            if (on_ticks > per_ticks) begin
                spi_fail <= 1'b1;
            end
            // write-one clears; a new event wins
            if (wr && PADDR == `CSW_A_STAT0) begin
                wake_input_event_flag <= wake_input_event_flag & ~PWDATA[0];
                gpio_event_flag <= gpio_event_flag & ~PWDATA[1];
            end
            if (stat_upd) begin
                wake_level_bit <= samp;
            end
            if (cyc_wake && stat_upd) begin
                wake_input_event_flag <= 1'b1;
            end
            if (static_wake && !cyc_cfg && wake_input_enable
                && SENSED_WAKE_INPUT != st_prev) begin
                wake_input_event_flag <= 1'b1;
            end
            if (gpio_wake_en && GPIO_WAKE_INPUT != gp_prev) begin
                gpio_event_flag <= 1'b1;
            end
            // mode sequencing and wake reaction
            case (mode)
                `CSW_MD_NORMAL, `CSW_MD_STOP: begin
                    if (cyc_wake || static_wake) begin
                        INTERRUPT_OUT_LOW <= 1'b0;
                    end
                    if (wr_mode && PWDATA[1:0] == `CSW_MD_SLEEP) begin
                        if (wake_input_event_flag || gpio_event_flag || no_source) begin
                            mode <= `CSW_MD_RESTART;
                            rst_cnt <= 8'h00;
                            RESET_OUT_LOW <= 1'b0;
                        end else begin
                            mode <= `CSW_MD_SLEEP;
                            MAIN_SUPPLY_RAIL <= 1'b0;
                        end
                    end else if (wr_mode && PWDATA[1:0] != `CSW_MD_RESTART) begin
                        mode <= PWDATA[1:0];
                    end
                end
                `CSW_MD_SLEEP: begin
                    if (cyc_wake || static_wake) begin
                        mode <= `CSW_MD_RESTART;
                        rst_cnt <= 8'h00;
                        MAIN_SUPPLY_RAIL <= 1'b1;
                        RESET_OUT_LOW <= 1'b0;
                    end
                end
                default: begin
                    MAIN_SUPPLY_RAIL <= 1'b1;
                    RESET_OUT_LOW <= 1'b0;
                    if (tick) begin
                        rst_cnt <= rst_cnt + 8'h01;
                        if (rst_cnt == 8'hff) begin
                            mode <= `CSW_MD_NORMAL;
                            RESET_OUT_LOW <= 1'b1;
                        end
                    end
                end
            endcase
            if (mode == `CSW_MD_NORMAL && !acc && RESET_OUT_LOW == 1'b0) begin
                RESET_OUT_LOW <= 1'b1;
            end
        end
    end
endmodule // csw_detector
`default_nettype wire

// ---- hw/csw_regs.vh ----
// constants and register map of the cyclic sense wake detector
// Function
// - timer periodically turns high-side driver on
// - evaluate wake input only during on-time
// - change wakes: interrupt or main supply
// - timer starts once valid on-time programmed
// - unprogrammed sole cyclic source forces restart
// - fault flag when on-time exceeds period
// - timer start with cyclic code relearns
// - first sample is reference only
// - 16us filter starts at on-time end
// - wake needs change and stable filter level
// - cyclic wake sets wake event flag
// - level status refreshed only from samples
// - stop mode updates only at shortest on-time
// - wake raised even if flag set
// - static sensing monitors enabled inputs continuously
// - cyclic waking driven only by timer
// - sixteen periods, fixed on-times or off
// - timer cleared in restart mode and on each timer register write
// - uncleared flags at sleep force restart
`ifndef CSW_REGS_VH
`define CSW_REGS_VH
`define CSW_A_TIMER   12'h000
`define CSW_A_GPIO    12'h004
`define CSW_A_WKCTL   12'h008
`define CSW_A_STAT0   12'h00c
`define CSW_A_STAT1   12'h010
`define CSW_A_MODE    12'h014
`define CSW_A_STATE   12'h018
`define CSW_GPIO_HSCS 3'h3
`define CSW_ON_OFFL   3'h0
`define CSW_ON_OFFH1  3'h6
`define CSW_ON_OFFH2  3'h7
`define CSW_ON_SHORT  3'h1
`define CSW_MD_NORMAL 2'h0
`define CSW_MD_STOP   2'h1
`define CSW_MD_SLEEP  2'h2
`define CSW_MD_RESTART 2'h3
`define CSW_CLK_KHZ   40000
`define CSW_FILT_NS   16000
`define CSW_FILT_CYC  16'd640 // 16us filter at 25ns per clock
`define CSW_TICK_DIV  16'd3999
`endif

// ---- hw/csw_tick.v ----
// divider giving a one-cycle pulse every 0.1 ms
`default_nettype none
module csw_tick (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        clr,      // restart the divider phase
    output reg         tick
);
`include "csw_regs.vh"
    reg [15:0] cnt; // cycle counter
    // count cycles, pulse on wrap
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (clr) begin
            // fresh phase, so a new on-time lasts whole ticks
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt == `CSW_TICK_DIV) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // csw_tick
`default_nettype wire

// ---- sim/csw_switch_model.sv ----
// external switch fed by the high-side driver, seen on the wake input
`default_nettype none
module csw_switch_model (
    input  wire logic hs_on,   // high-side supply to the switch
    input  wire logic closed,  // switch position set by the bench
    output logic      sense    // level at the sensed wake input
);
    // unpowered switch lets the pull-down win, so no stale level remains
    assign sense = hs_on & closed;
endmodule // csw_switch_model
`default_nettype wire

// ---- sim/csw_detector_asserts.sv ----
// port-level assertions for the cyclic sense wake detector
`default_nettype none
module csw_detector_asserts (
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        HIGH_SIDE_DRIVER,
    input wire logic        INTERRUPT_OUT_LOW,
    input wire logic        MAIN_SUPPLY_RAIL,
    input wire logic        RESET_OUT_LOW
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    logic [19:0] hs_cnt;  // cycles the driver has stayed on
    // count on-time length, saturating
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N)
            hs_cnt <= 20'h0;
        else if (!HIGH_SIDE_DRIVER)
            hs_cnt <= 20'h0;
        else if (hs_cnt != 20'hfffff)
            hs_cnt <= hs_cnt + 20'h1;
    end
    a_ready_access: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access cycle without ready");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error response outside access cycle");
    a_int_pulse: assert property ($fell(INTERRUPT_OUT_LOW) |=> INTERRUPT_OUT_LOW)
        else $error("interrupt pulse longer than one cycle");
    a_sleep_no_int: assert property (!MAIN_SUPPLY_RAIL |-> INTERRUPT_OUT_LOW)
        else $error("interrupt driven while supply is off");
    a_hs_min_on: assert property ($rose(HIGH_SIDE_DRIVER) && RESET_OUT_LOW |=> HIGH_SIDE_DRIVER[*8])
        else $error("on-time shorter than shortest setting");
    a_hs_max_on: assert property (hs_cnt <= 20'd801000)
        else $error("on-time longer than longest setting");
    a_restart_hs_off: assert property (!RESET_OUT_LOW |-> !HIGH_SIDE_DRIVER)
        else $error("driver on during restart");
    a_wake_rail: assert property ($rose(MAIN_SUPPLY_RAIL) |-> ##[0:4] !RESET_OUT_LOW)
        else $error("supply return without restart");
    c_hs_on: cover property ($rose(HIGH_SIDE_DRIVER));
    c_slverr: cover property (PSLVERR);
    c_restart: cover property ($fell(RESET_OUT_LOW));
endmodule // csw_detector_asserts
bind csw_detector csw_detector_asserts u_chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .HIGH_SIDE_DRIVER(HIGH_SIDE_DRIVER),
    .INTERRUPT_OUT_LOW(INTERRUPT_OUT_LOW), .MAIN_SUPPLY_RAIL(MAIN_SUPPLY_RAIL),
    .RESET_OUT_LOW(RESET_OUT_LOW));
`default_nettype wire

// ---- sim/csw_detector_tb.sv ----
// self-checking bench for the cyclic sense wake detector
`default_nettype none
`include "csw_regs.vh"
module csw_detector_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n;            // core clock and reset
    logic        psel, penable, pwrite; // apb request
    logic [11:0] paddr;                 // apb address
    logic [31:0] pwdata, prdata;        // apb data
    logic        pready, pslverr;       // apb answer
    logic        sense, gwake, closed;  // wake inputs, switch
    logic        hs, int_n, supply, rso_n; // device outputs
    logic [31:0] d;                     // read data
    logic        e;                     // read error
    int          errors, checked, cyc, ints, n;
    csw_detector dut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SENSED_WAKE_INPUT(sense), .GPIO_WAKE_INPUT(gwake),
        .HIGH_SIDE_DRIVER(hs), .INTERRUPT_OUT_LOW(int_n), .MAIN_SUPPLY_RAIL(supply),
        .RESET_OUT_LOW(rso_n));
    csw_switch_model u_sw (.hs_on(hs), .closed(closed), .sense(sense));
    // clock generation
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // cycle ceiling and interrupt pulse counter
    always @(posedge clk) begin
        cyc++;
        if (int_n === 1'b0)
            ints++;
        if (cyc == 60000) begin
            errors++;
            stop_test;
        end
    end
    task stop_test;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, d & m, x);
    endtask
    task automatic wait_out(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("wait_level", n < lim, 1);
    endtask
    task do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wait_out(rso_n, 1'b1, 200);
    endtask
    task gpio_event;
        apb(1'b1, `CSW_A_WKCTL, 32'h2);
        gwake <= 1'b1;
        repeat (50) @(posedge clk);
        gwake <= 1'b0;
        rdm(`CSW_A_STAT0, 32'h2, 32'h2, "gpio_event");
    endtask
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, gwake, closed} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        do_reset;
        check("int_idle", int_n, 1);
        check("supply_on", supply, 1);
        rdm(`CSW_A_TIMER, 32'h7f, 32'h0, "timer_rst");
        rdm(`CSW_A_STAT0, 32'h3, 32'h0, "stat0_rst");
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped_data", d, 32'h0);
        check("unmapped_err", e, 1);
        // static gpio wake, then write-one-clear
        ints = 0;
        gpio_event;
        check("gpio_int", ints > 0, 1);
        apb(1'b1, `CSW_A_STAT0, 32'h2);
        rdm(`CSW_A_STAT0, 32'h2, 32'h0, "stat0_clear");
        // cyclic sense set up in the required order, shortest on-time
        closed <= 1'b1;
        apb(1'b1, `CSW_A_WKCTL, 32'h0);
        apb(1'b1, `CSW_A_GPIO, {29'h0, `CSW_GPIO_HSCS});
        apb(1'b1, `CSW_A_WKCTL, 32'h1);
        ints = 0;
        apb(1'b1, `CSW_A_TIMER, {25'h0, `CSW_ON_SHORT, 4'h0});
        wait_out(hs, 1'b1, 8);
        n = 0;
        while (hs === 1'b1 && n < 50000) begin
            @(posedge clk);
            n++;
        end
        // one 0.1ms tick of on-time, then the driver holds through the filter
        check("ontime_len", n >= 4000 + `CSW_FILT_CYC
              && n <= 4004 + `CSW_FILT_CYC, 1);
        rdm(`CSW_A_TIMER, 32'h7f, 32'h10, "timer_rb");
        repeat (1000) @(posedge clk);
        check("hs_off", hs, 0);
        check("first_ref", ints, 0);
        rdm(`CSW_A_STAT0, 32'h1, 32'h0, "no_event");
        rdm(`CSW_A_STAT1, 32'h1, 32'h1, "lvl_sampled");
        // on-time longer than period raises the fault
        apb(1'b1, `CSW_A_TIMER, 32'h50);
        rdm(`CSW_A_STATE, 32'h20, 32'h20, "fault_set");
        apb(1'b1, `CSW_A_TIMER, 32'h10);
        apb(1'b1, `CSW_A_STAT1, 32'h20);
        rdm(`CSW_A_STATE, 32'h20, 32'h0, "fault_clr");
        // sleep request with an uncleared flag
        gpio_event;
        apb(1'b1, `CSW_A_MODE, {30'h0, `CSW_MD_SLEEP});
        wait_out(rso_n, 1'b0, 2000);
        check("restart_hs", hs, 0);
        // programmed cyclic source lets the device sleep
        do_reset;
        apb(1'b1, `CSW_A_GPIO, {29'h0, `CSW_GPIO_HSCS});
        apb(1'b1, `CSW_A_WKCTL, 32'h1);
        apb(1'b1, `CSW_A_TIMER, {25'h0, `CSW_ON_SHORT, 4'h0});
        apb(1'b1, `CSW_A_MODE, {30'h0, `CSW_MD_SLEEP});
        wait_out(supply, 1'b0, 4);
        check("sleep_no_rst", rso_n, 1);
        // cyclic as only source with the timer unprogrammed
        do_reset;
        apb(1'b1, `CSW_A_GPIO, {29'h0, `CSW_GPIO_HSCS});
        apb(1'b1, `CSW_A_WKCTL, 32'h1);
        apb(1'b1, `CSW_A_MODE, {30'h0, `CSW_MD_SLEEP});
        wait_out(rso_n, 1'b0, 2000);
        check("rst_supply", supply, 1);
        stop_test;
    end
endmodule // csw_detector_tb
`default_nettype wire
